//--- hdl/periodic_timer_pkg.sv
// Purpose: Constants and carriers for the periodic down timer
// Assumes: AXI4-Lite slave, 32-bit data, one clock
// Notes:   Register offsets are byte addresses within a 4K window
package periodic_timer_pkg;
  localparam int          COUNT_W          = 24;
  localparam logic [31:0] IRQ_CTRL_BASE    = 32'hE000_0000;
  localparam logic [31:0] TIMER_BASE_OFS   = 32'h0000_1000;
  localparam logic [7:0]  EXC_VECTOR       = 8'h18;
  localparam int          WINDOW_BITS      = 12;
  localparam logic [11:0] OFS_CTRL_STATUS  = 12'h000;
  localparam logic [11:0] OFS_RELOAD       = 12'h004;
  localparam logic [11:0] OFS_COUNT        = 12'h008;
  localparam logic [11:0] OFS_IRQ_STATUS   = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MASK     = 12'h010;
  localparam int          BIT_RUN          = 0;
  localparam int          BIT_IRQ_EN       = 1;
  localparam int          BIT_CLK_SEL      = 2;
  localparam int          BIT_ZERO_FLAG    = 3;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam logic [23:0] COUNT_ZERO       = 24'h00_0000;

  typedef struct packed {
    logic                run;
    logic                irq_en;
    logic                clk_sel;
    logic                zero_flag;
    logic [COUNT_W-1:0]  reload;
    logic [COUNT_W-1:0]  count;
  } timer_regs_t;

  typedef struct packed {
    logic        aw_got;
    logic [11:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bus_state_t;
endpackage

//--- hdl/periodic_down_timer.sv
// Purpose: Programmable 24-bit periodic down timer with AXI4-Lite registers
// Assumes: ext_ref_clk is asynchronous and much slower than clk
// Notes:   External reference ticks on its synchronised rising edge
`timescale 1ns/1ps
`default_nettype none
module periodic_down_timer
  import periodic_timer_pkg::*;
#(
  parameter bit          TIMER_PRESENT = 1'b1,
  parameter logic [31:0] BASE_ADDR     = IRQ_CTRL_BASE + TIMER_BASE_OFS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ext_ref_clk,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             exc_request,
  output logic [7:0]       exc_vector,
  output logic             irq
);

  typedef struct packed {
    timer_regs_t t;
    bus_state_t  b;
    logic [2:0]  ref_sync;
    logic        irq_status;
    logic        irq_mask;
    logic [3:0]  w_strb;
    logic        exc_request;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        arready;
  } state_t;

  state_t s;
  state_t next_s;

  localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;
  localparam int                 LANES     = 3;
  localparam int                 LANE_W    = 8;
  localparam logic [11:0]        OFS_ALL   = OFS_CTRL_STATUS | OFS_RELOAD | OFS_COUNT | OFS_IRQ_STATUS | OFS_IRQ_MASK;

  // Refuse a base that the 4K decode cannot serve
  if (BASE_ADDR[WINDOW_BITS-1:0] != '0) begin : g_bad_base
    $error("BASE_ADDR must be 4K aligned");
  end

  // The reload byte lanes cover exactly the counter width
  if (COUNT_W != LANES * LANE_W) begin : g_bad_width
    $error("COUNT_W must match the reload byte lanes");
  end

  // Register offsets must be whole words
  if (OFS_ALL[1:0] != 2'b00) begin : g_bad_ofs
    $error("register offsets must be word aligned");
  end

  // Field positions must fit in the data word
  if (BIT_ZERO_FLAG >= $bits(s_axi_rdata) || BIT_CLK_SEL >= $bits(s_axi_rdata)) begin : g_bad_bits
    $error("control field outside the data word");
  end

  // Offset decode is fixed at twelve address bits
  if (WINDOW_BITS != $bits(OFS_COUNT)) begin : g_bad_window
    $error("WINDOW_BITS must match the offset width");
  end

  // Unused protection bits and the lane 3 strobe: all privilege levels may access
  logic prot_unused;
  assign prot_unused = ^{s_axi_awprot, s_axi_arprot, s.w_strb[3]};

  // Control/status word as software sees it
  function automatic logic [31:0] status_word(input timer_regs_t r);
    logic [31:0] w;
    w                = 32'h0000_0000;
    w[BIT_RUN]       = r.run;
    w[BIT_IRQ_EN]    = r.irq_en;
    w[BIT_CLK_SEL]   = r.clk_sel;
    w[BIT_ZERO_FLAG] = r.zero_flag;
    return w;
  endfunction

  // Byte lanes 0..2 carry the reload; lane 3 has no storage
  function automatic logic [COUNT_W-1:0] merge_lanes(
    input logic [COUNT_W-1:0] old,
    input logic [31:0]        data,
    input logic [3:0]         strb
  );
    logic [COUNT_W-1:0] m;
    m = old;
    for (int lane = 0; lane < LANES; lane++) begin
      if (strb[lane]) begin
        m[lane*LANE_W +: LANE_W] = data[lane*LANE_W +: LANE_W];
      end
    end
    return m;
  endfunction

  // Offsets that hold a register; the rest of the window is reserved
  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    case (a)
      OFS_CTRL_STATUS: hit = 1'b1;
      OFS_RELOAD:      hit = 1'b1;
      OFS_COUNT:       hit = 1'b1;
      OFS_IRQ_STATUS:  hit = 1'b1;
      OFS_IRQ_MASK:    hit = 1'b1;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  // One count-clock step of the down counter
  function automatic logic [COUNT_W-1:0] count_step(
    input logic [COUNT_W-1:0] count,
    input logic [COUNT_W-1:0] reload
  );
    logic [COUNT_W-1:0] c;
    c = count;
    if (count == COUNT_ZERO) begin
      // A zero reload leaves the counter parked at zero
      if (reload != COUNT_ZERO) begin
        c = reload;
      end
    end else begin
      c = count - COUNT_ONE;
    end
    return c;
  endfunction

  always_comb begin
    logic        tick;
    logic        ref_rise;
    logic        wr_go;
    logic        rd_go;
    logic        in_win;
    logic [11:0] ofs;
    logic [11:0] rd_ofs;
    logic        hit_zero;
    logic        aw_take;
    logic        w_take;
    logic        b_done;
    logic        r_done;

    // Scratch values, all given a value first
    tick     = 1'b0;
    ref_rise = 1'b0;
    wr_go    = 1'b0;
    rd_go    = 1'b0;
    in_win   = 1'b0;
    ofs      = s.b.aw_addr;
    rd_ofs   = s_axi_araddr[11:0];
    hit_zero = 1'b0;
    aw_take  = 1'b0;
    w_take   = 1'b0;
    b_done   = 1'b0;
    r_done   = 1'b0;
    next_s   = s;

    // Two sync stages; stage 2 only remembers the prior level
    next_s.ref_sync = {s.ref_sync[1:0], ext_ref_clk};
    ref_rise        = s.ref_sync[1] & ~s.ref_sync[2];
    // Core clock ticks every cycle; reference only on its rising edge
    if (s.t.clk_sel) begin
      tick = 1'b1;
    end else begin
      tick = ref_rise;
    end

    // Counter holds while stopped
    // Flag only on the 1 to 0 step, never on a reload
    if (s.t.run && tick) begin
      next_s.t.count = count_step(s.t.count, s.t.reload);
      hit_zero       = (s.t.count == COUNT_ONE);
    end

    // Write address: one-cycle ready pulse, then held until used
    // Upper address bits ignored inside the window
    next_s.awready = 1'b0;
    aw_take        = s_axi_awvalid && !s.b.aw_got && !s.awready;
    if (aw_take) begin
      next_s.awready   = 1'b1;
      next_s.b.aw_got  = 1'b1;
      next_s.b.aw_addr = s_axi_awaddr[11:0];
    end

    // Write data and strobes, taken independently of the address
    next_s.wready = 1'b0;
    w_take        = s_axi_wvalid && !s.b.w_got && !s.wready;
    if (w_take) begin
      next_s.wready   = 1'b1;
      next_s.b.w_got  = 1'b1;
      next_s.b.w_data = s_axi_wdata;
      next_s.w_strb   = s_axi_wstrb;
    end

    // Commit once both halves are in and the last answer is gone
    wr_go  = s.b.aw_got && s.b.w_got && !s.b.bvalid;
    ofs    = s.b.aw_addr;
    in_win = is_mapped(ofs);
    if (wr_go) begin
      next_s.b.aw_got = 1'b0;
      next_s.b.w_got  = 1'b0;
      next_s.b.bvalid = 1'b1;
      // Reserved offsets swallow the write and still answer OKAY
      next_s.b.bresp  = RESP_OKAY;
      if (in_win) begin
        case (ofs)
          OFS_CTRL_STATUS: begin
            next_s.t.run     = s.b.w_data[BIT_RUN];
            next_s.t.irq_en  = s.b.w_data[BIT_IRQ_EN];
            next_s.t.clk_sel = s.b.w_data[BIT_CLK_SEL];
          end
          OFS_RELOAD: begin
            // Strobes were captured together with the data
            next_s.t.reload = merge_lanes(s.t.reload, s.b.w_data, s.w_strb);
          end
          OFS_COUNT: begin
            // Any data: the value written is discarded
            next_s.t.count     = COUNT_ZERO;
            next_s.t.zero_flag = 1'b0;
          end
          OFS_IRQ_STATUS: begin
            // Write one to clear
            if (s.b.w_data[0]) begin
              next_s.irq_status = 1'b0;
            end
          end
          OFS_IRQ_MASK: begin
            next_s.irq_mask = s.b.w_data[0];
          end
          default: begin
            next_s.b.bresp = RESP_OKAY;
          end
        endcase
      end
    end

    // Response stands until the master takes it
    b_done = s.b.bvalid && s_axi_bready;
    if (b_done) begin
      next_s.b.bvalid = 1'b0;
    end

    // Read: arready and rvalid rise together, one read at a time
    // Offsets decoded from the low twelve bits only
    next_s.arready = 1'b0;
    rd_go          = s_axi_arvalid && !s.arready && !s.b.rvalid;
    rd_ofs         = s_axi_araddr[11:0];
    if (rd_go) begin
      next_s.arready  = 1'b1;
      next_s.b.rvalid = 1'b1;
      next_s.b.rresp  = RESP_OKAY;
      next_s.b.rdata  = 32'h0000_0000;
      case (rd_ofs)
        OFS_CTRL_STATUS: begin
          next_s.b.rdata = status_word(s.t);
          // Reading is the acknowledge; a zero event below still wins
          next_s.t.zero_flag = 1'b0;
        end
        OFS_RELOAD: begin
          next_s.b.rdata[COUNT_W-1:0] = s.t.reload;
        end
        OFS_COUNT: begin
          next_s.b.rdata[COUNT_W-1:0] = s.t.count;
        end
        OFS_IRQ_STATUS: begin
          next_s.b.rdata[0] = s.irq_status;
        end
        OFS_IRQ_MASK: begin
          next_s.b.rdata[0] = s.irq_mask;
        end
        default: begin
          // Reserved reads return zero with OKAY
          next_s.b.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Read data stands until the master takes it
    r_done = s.b.rvalid && s_axi_rready;
    if (r_done) begin
      next_s.b.rvalid = 1'b0;
    end

    // Set wins over every clear of the same cycle
    if (hit_zero) begin
      next_s.t.zero_flag = 1'b1;
      next_s.irq_status  = 1'b1;
    end

    // Registered from the next state so they track the flags
    next_s.exc_request = next_s.t.zero_flag & next_s.t.irq_en;
    // Sticky status gated by its mask
    next_s.irq         = next_s.irq_status & next_s.irq_mask;

    // Absent timer: every flop stays at its reset value
    if (!TIMER_PRESENT) begin
      next_s = '0;
    end
  end

  // Async reset puts every register at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Every output straight from a flop, except exc_vector, which is the constant EXC_VECTOR
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.b.bvalid;
  assign s_axi_bresp   = s.b.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.b.rvalid;
  assign s_axi_rdata   = s.b.rdata;
  assign s_axi_rresp   = s.b.rresp;

  assign exc_request   = s.exc_request;
  assign exc_vector    = EXC_VECTOR;
  assign irq           = s.irq;
endmodule
`default_nettype wire

//--- dv/periodic_timer_sva.sv
// Purpose: Port checker for periodic_down_timer
// Assumes: One clock, async active-high reset
// Notes:   Bound below; watches dut outputs except wready, and the bready, arvalid and rready inputs
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  exc_vector,
  input wire logic        exc_request,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_vec; exc_vector == 8'h18; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_arr; s_axi_arready |-> s_axi_rvalid; endproperty
  a_arr: assert property (p_arr) else $error("arready without rvalid");
  property p_ar; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read not answered");
  property p_aw; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("awready too long");
  property p_okb; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_okb: assert property (p_okb) else $error("bresp not okay");
  property p_okr; s_axi_rvalid |-> s_axi_rresp == 2'h0; endproperty
  a_okr: assert property (p_okr) else $error("rresp not okay");
  c_exc: cover property (exc_request);
  c_irq: cover property (irq);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind periodic_down_timer periodic_timer_sva u_sva (.*);
`default_nettype wire

//--- dv/tb_periodic_down_timer.sv
// Purpose: Self-checking bench for periodic_down_timer
// Assumes: Reference clock toggles every 8 core cycles
// Notes:   Period taken between request edges
`timescale 1ns/1ps
`default_nettype none
module tb_periodic_down_timer;
  logic        clk, rst, ext_ref_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exc_request, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v, c;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  exc_vector;
  int          num_errors, compares, cyc, t, n;
  periodic_down_timer dut (.*);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 0) ext_ref_clk <= ~ext_ref_clk;
    if (cyc > 20000) begin
      num_errors++;
      summarize();
    end
  end
  task summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd, a1, w1;
    @(posedge clk);
    {ad, wd} = 2'b00;
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(negedge clk);
      {a1, w1} = {s_axi_awready, s_axi_wready};
      @(posedge clk);
      if (a1) s_axi_awvalid <= 1'b0;
      if (w1) s_axi_wvalid <= 1'b0;
      ad |= a1;
      wd |= w1;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= {20'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    @(posedge clk);
    {s_axi_arvalid, s_axi_rready} <= 2'b00;
  endtask
  task rise();
    do @(negedge clk); while (exc_request !== 1'b1);
    t = cyc;
  endtask
  initial begin
    {clk, rst, ext_ref_clk} = 3'b010;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h6148));
    // Long enough that bus traffic fits inside one period
    n = 20 + int'($urandom % 40);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, v);
    chk("csr reset", v, 32'h0000_0000);
    chk("vector", {24'h0, exc_vector}, 32'h0000_0018);
    rd(12'h100, v);
    chk("unmapped", v, 32'h0000_0000);
    wr(12'h004, 32'hFFFF_FFFF);
    rd(12'h004, v);
    chk("reload", v, 32'h00FF_FFFF);
    wr(12'h008, $urandom);
    rd(12'h008, v);
    chk("count clr", v, 32'h0000_0000);
    wr(12'h004, 32'h0000_0000);
    wr(12'h000, 32'h0000_0005);
    repeat (20) @(posedge clk);
    rd(12'h008, v);
    chk("reload zero", v, 32'h0000_0000);
    wr(12'h004, 32'(n));
    wr(12'h000, 32'h0000_0007);
    rise();
    c = 32'(t);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(12'h010, 32'h0000_0001);
    rd(12'h000, v);
    chk("csr flag", v, 32'h0000_000F);
    rd(12'h000, v);
    chk("flag clr", v, 32'h0000_0007);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    rise();
    chk("period", 32'(t) - c, 32'(n + 1));
    wr(12'h000, 32'h0000_0005);
    repeat (2 * n + 4) @(posedge clk);
    chk("no request", {31'h0, exc_request}, 32'h0000_0000);
    rd(12'h000, v);
    chk("flag no en", v, 32'h0000_000D);
    wr(12'h000, 32'h0000_0000);
    rd(12'h008, c);
    repeat (2 * n + 4) @(posedge clk);
    rd(12'h008, v);
    chk("hold", v, c);
    chk("range", {31'h0, c <= 32'(n)}, 32'h0000_0001);
    rd(12'h000, v);
    rd(12'h000, v);
    chk("stopped", v, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0001);
    rd(12'h00C, v);
    chk("sticky clr", v, 32'h0000_0000);
    chk("irq low", {31'h0, irq}, 32'h0000_0000);
    wr(12'h008, 32'h0000_0000);
    wr(12'h000, 32'h0000_0001);
    // Slow reference: about ten ticks land in this wait
    repeat (160) @(posedge clk);
    rd(12'h008, v);
    chk("ext clock", {31'h0, v <= 32'(n) && v + 12 >= 32'(n)}, 32'h0000_0001);
    summarize();
  end
endmodule
`default_nettype wire
